// file: psp_pkg.sv
// shared constants and types for the pressure sensor serial target port
// Behaviour
// - answer seven-bit address, low bit from pin
// - start is data falling while clock high
// - eighth bit after address selects read/write
// - acknowledge own address by pulling data low
// - stop is data rising while clock high
// - data changes only while clock low
// - command nibble 1000b launches temperature conversion
// - command nibble 1001b launches pressure conversion
// - nibble 1010b runs temperature then pressure
// - pressure result readable high byte first
// - temperature high byte at 0x09, low next
package psp_pkg;
  localparam logic [5:0] OWN_ADDR_HI = 6'h36; // fixed upper address bits
  localparam logic [7:0] IDX_P_HI = 8'h06; // pressure high byte
  localparam logic [7:0] IDX_P_MID = 8'h07; // pressure middle byte
  localparam logic [7:0] IDX_P_LO = 8'h08; // pressure low byte
  localparam logic [7:0] IDX_T_HI = 8'h09; // temperature high byte
  localparam logic [7:0] IDX_T_LO = 8'h0A; // temperature low byte
  localparam logic [7:0] IDX_CMD = 8'h30; // measurement command
  localparam logic [7:0] RST_BYTE = 8'h00; // reset value of every register
  localparam logic [3:0] CMD_TEMP = 4'h8; // single temperature conversion
  localparam logic [3:0] CMD_PRESS = 4'h9; // single pressure conversion
  localparam logic [3:0] CMD_BOTH = 4'hA; // temperature then pressure
  localparam logic [3:0] BITS_IN = 4'h8; // bits of a received byte
  localparam logic [3:0] LAST_TX = 4'h7; // index of last sent bit
  localparam logic LINE_IDLE = 1'b1; // bus lines idle high

  // link states
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} psp_state_t;
  // which byte of a write is being received
  typedef enum logic [1:0] {PH_ADDR, PH_IDX, PH_DATA} psp_phase_t;

  // conversion results from the sensor core
  typedef struct packed {
    logic t_vld;
    logic [15:0] t;
    logic p_vld;
    logic [23:0] p;
  } psp_res_t;

  // register write strobe
  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [7:0] data;
  } psp_wr_t;

  // state of the serial engine
  typedef struct packed {
    psp_state_t state;
    psp_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] idx;
    logic rd;
    logic nack;
    logic scl_d;
    logic sda_d;
    logic sda_o;
    logic oe;
    logic pend;
    logic start_t;
    logic start_p;
  } psp_port_t;

  // state of the register store
  typedef struct packed {
    logic [7:0] cmd;
    logic [23:0] press;
    logic [15:0] temp;
    logic [7:0] rdata;
  } psp_mem_t;
endpackage

// file: psp_regs.sv
// register store with registered read port
`timescale 1ns/1ps
module psp_regs
  import psp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire psp_wr_t wr_i,
  input wire logic [7:0] rd_idx_i,
  input wire psp_res_t res_i,
  output logic [7:0] rdata_o
);
  psp_mem_t st_reg; // registered state
  psp_mem_t st_next; // next state

  // read mux, unmapped indices read zero
  function automatic logic [7:0] rd_mux(input psp_mem_t s, input logic [7:0] idx);
    case (idx)
      IDX_P_HI: rd_mux = s.press[23:16];
      IDX_P_MID: rd_mux = s.press[15:8];
      IDX_P_LO: rd_mux = s.press[7:0];
      IDX_T_HI: rd_mux = s.temp[15:8];
      IDX_T_LO: rd_mux = s.temp[7:0];
      IDX_CMD: rd_mux = s.cmd;
      default: rd_mux = RST_BYTE;
    endcase
  endfunction

  // results load, command writes, read data refresh
  always_comb
  begin
    st_next = st_reg;
    if (res_i.p_vld)
    begin
      st_next.press = res_i.p;
    end
    if (res_i.t_vld)
    begin
      st_next.temp = res_i.t;
    end
    // only the command register is writable
    if (wr_i.en && wr_i.idx == IDX_CMD)
    begin
      st_next.cmd = wr_i.data;
    end
    st_next.rdata = rd_mux(st_reg, rd_idx_i);
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;

  // pressure high byte read out the cycle after its index
  property p_press_rd;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_idx_i == IDX_P_HI) |=> (rdata_o == $past(st_reg.press[23:16]));
  endproperty
  a_press_rd: assert property (p_press_rd) else $error("pressure high byte misread");

  // temperature low byte read out the cycle after its index
  property p_temp_rd;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_idx_i == IDX_T_LO) |=> (rdata_o == $past(st_reg.temp[7:0]));
  endproperty
  a_temp_rd: assert property (p_temp_rd) else $error("temperature low byte misread");
endmodule

// file: psp_port.sv
// serial target port of the pressure sensor with conversion launch
`timescale 1ns/1ps
module psp_port
  import psp_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic ADDR_SEL_I,
  input wire logic TEMP_VALID_I,
  input wire logic [15:0] TEMP_DATA_I,
  input wire logic PRESS_VALID_I,
  input wire logic [23:0] PRESS_DATA_I,
  output logic START_TEMP_O,
  output logic START_PRESS_O
);
  psp_port_t st_reg; // registered state
  psp_port_t st_next; // next state
  psp_wr_t wr; // register write strobe
  psp_res_t res; // results to the store
  logic [7:0] rdata; // registered read data
  logic scl_rise; // clock rising edge
  logic scl_fall; // clock falling edge
  logic start_det; // start condition seen
  logic stop_det; // stop condition seen
  logic byte_done; // eighth bit in, clock now low
  logic addr_hit; // address byte matches ours

  // line events from last and current samples
  always_comb
  begin
    scl_rise = !st_reg.scl_d && SCL_I;
    scl_fall = st_reg.scl_d && !SCL_I;
    start_det = st_reg.scl_d && SCL_I && st_reg.sda_d && !SDA_I;
    stop_det = st_reg.scl_d && SCL_I && !st_reg.sda_d && SDA_I;
    byte_done = st_reg.state == ST_RX && scl_fall && st_reg.cnt == BITS_IN;
    addr_hit = st_reg.shreg[7:1] == {OWN_ADDR_HI, ADDR_SEL_I};
  end

  // results bundle
  always_comb
  begin
    res.t_vld = TEMP_VALID_I;
    res.t = TEMP_DATA_I;
    res.p_vld = PRESS_VALID_I;
    res.p = PRESS_DATA_I;
  end

  // serial engine and conversion launch
  always_comb
  begin
    st_next = st_reg;
    st_next.scl_d = SCL_I;
    st_next.sda_d = SDA_I;
    st_next.start_t = 1'b0;
    st_next.start_p = 1'b0;
    wr = '0;
    if (start_det)
    begin
      // start or repeated start restarts the address phase
      st_next.state = ST_RX;
      st_next.phase = PH_ADDR;
      st_next.cnt = '0;
      st_next.oe = 1'b0;
    end
    else if (stop_det)
    begin
      // stop frees the bus
      st_next.state = ST_IDLE;
      st_next.oe = 1'b0;
    end
    else
    begin
      case (st_reg.state)
        ST_RX:
        begin
          if (scl_rise && st_reg.cnt != BITS_IN)
          begin
            // sample data on rising clock
            st_next.shreg = {st_reg.shreg[6:0], SDA_I};
            st_next.cnt = st_reg.cnt + 4'h1;
          end
          else if (byte_done)
          begin
            st_next.cnt = '0;
            case (st_reg.phase)
              PH_ADDR:
              begin
                if (addr_hit)
                begin
                  // direction bit then acknowledge
                  st_next.rd = st_reg.shreg[0];
                  st_next.state = ST_ACK;
                  st_next.oe = 1'b1;
                end
                else
                begin
                  // not ours, wait for next start
                  st_next.state = ST_IDLE;
                end
              end
              PH_IDX:
              begin
                // register index byte
                st_next.idx = st_reg.shreg;
                st_next.phase = PH_DATA;
                st_next.state = ST_ACK;
                st_next.oe = 1'b1;
              end
              default:
              begin
                // data byte to current index
                wr.en = 1'b1;
                wr.idx = st_reg.idx;
                wr.data = st_reg.shreg;
                st_next.idx = st_reg.idx + 8'h01;
                st_next.state = ST_ACK;
                st_next.oe = 1'b1;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          // release or start sending on falling clock
          if (scl_fall)
          begin
            if (st_reg.rd)
            begin
              st_next.shreg = rdata;
              st_next.oe = !rdata[7];
              st_next.state = ST_TX;
            end
            else
            begin
              st_next.oe = 1'b0;
              st_next.state = ST_RX;
              if (st_reg.phase == PH_ADDR)
              begin
                st_next.phase = PH_IDX;
              end
            end
          end
        end
        ST_TX:
        begin
          // next bit only after clock falls
          if (scl_fall)
          begin
            if (st_reg.cnt == LAST_TX)
            begin
              st_next.oe = 1'b0;
              st_next.state = ST_MACK;
              st_next.idx = st_reg.idx + 8'h01;
            end
            else
            begin
              st_next.shreg = {st_reg.shreg[6:0], 1'b0};
              st_next.oe = !st_reg.shreg[6];
              st_next.cnt = st_reg.cnt + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          // master acknowledge decides continue or end
          if (scl_rise)
          begin
            st_next.nack = SDA_I;
          end
          else if (scl_fall)
          begin
            st_next.cnt = '0;
            if (st_reg.nack)
            begin
              st_next.state = ST_IDLE;
            end
            else
            begin
              st_next.shreg = rdata;
              st_next.oe = !rdata[7];
              st_next.state = ST_TX;
            end
          end
        end
        default:
        begin
          st_next.oe = 1'b0;
        end
      endcase
    end
    // pending pressure after temperature finishes
    if (st_reg.pend && TEMP_VALID_I)
    begin
      st_next.pend = 1'b0;
      st_next.start_p = 1'b1;
    end
    // command write launches conversions, set beats clear
    if (wr.en && wr.idx == IDX_CMD)
    begin
      case (wr.data[3:0])
        CMD_TEMP: st_next.start_t = 1'b1;
        CMD_PRESS: st_next.start_p = 1'b1;
        CMD_BOTH:
        begin
          st_next.start_t = 1'b1;
          st_next.pend = 1'b1;
        end
        default: st_next.pend = st_next.pend;
      endcase
    end
  end

  // state register
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st_reg <= '0;
      st_reg.scl_d <= LINE_IDLE;
      st_reg.sda_d <= LINE_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // register store
  psp_regs u_psp_regs (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .wr_i(wr),
    .rd_idx_i(st_reg.idx),
    .res_i(res),
    .rdata_o(rdata)
  );

  // outputs straight from flops
  assign SDA_O = st_reg.sda_o;
  assign SDA_OE_O = st_reg.oe;
  assign START_TEMP_O = st_reg.start_t;
  assign START_PRESS_O = st_reg.start_p;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_cmd(logic [3:0] code);
    wr.en && wr.idx == IDX_CMD && wr.data[3:0] == code;
  endsequence
  property p_foreign;
    byte_done && st_reg.phase == PH_ADDR && !addr_hit |=> st_reg.state == ST_IDLE && !SDA_OE_O;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address answered");
  property p_start;
    start_det |=> st_reg.state == ST_RX && st_reg.cnt == 4'h0 && st_reg.phase == PH_ADDR;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_dir;
    byte_done && st_reg.phase == PH_ADDR && addr_hit |=> st_reg.rd == $past(st_reg.shreg[0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit lost");
  property p_ack;
    byte_done && st_reg.phase == PH_ADDR && addr_hit && !SCL_I ##1 !SCL_I |-> SDA_OE_O && !SDA_O;
  endproperty
  a_ack: assert property (p_ack) else $error("address not acknowledged");
  property p_stop;
    stop_det |=> st_reg.state == ST_IDLE && !SDA_OE_O;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_stable;
    st_reg.scl_d && SCL_I && !start_det && !stop_det |=> $stable(SDA_OE_O);
  endproperty
  a_stable: assert property (p_stable) else $error("data moved with clock high");
  property p_temp;
    s_cmd(CMD_TEMP) |=> START_TEMP_O && !START_PRESS_O ##1 !START_TEMP_O;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature launch wrong");
  property p_press;
    s_cmd(CMD_PRESS) |=> START_PRESS_O && !START_TEMP_O;
  endproperty
  a_press: assert property (p_press) else $error("pressure launch wrong");
  property p_both;
    s_cmd(CMD_BOTH) |=> START_TEMP_O && st_reg.pend;
  endproperty
  a_both: assert property (p_both) else $error("combined launch wrong");
  property p_chain;
    st_reg.pend && TEMP_VALID_I && !wr.en |=> START_PRESS_O && !st_reg.pend;
  endproperty
  a_chain: assert property (p_chain) else $error("pressure not chained");
  property p_inc;
    st_reg.state == ST_TX && scl_fall && st_reg.cnt == LAST_TX |=> st_reg.idx == $past(st_reg.idx) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("index not advanced");
endmodule

// file: psp_master.sv
// bus master model that drives the sensor's serial port
`timescale 1ns/1ps
module psp_master
  import psp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // both lines released at time zero
  initial
  begin
    scl_o = LINE_IDLE;
    sda_low_o = 1'b0;
  end
  // wait n system clocks, always ending on a falling edge
  task automatic dly(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // one bit: data set while clock low, sampled in the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low_o = ~b;
    dly(3);
    scl_o = 1'b1;
    dly(2);
    r = sda_i;
    dly(2);
    scl_o = 1'b0;
    dly(1);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_low_o = 1'b0;
    dly(2);
    scl_o = 1'b1;
    dly(4);
    sda_low_o = 1'b1;
    dly(4);
    scl_o = 1'b0;
    dly(2);
  endtask
  // stop: data rises while clock high, then bus idle
  task automatic stop();
    sda_low_o = 1'b1;
    dly(2);
    scl_o = 1'b1;
    dly(4);
    sda_low_o = 1'b0;
    dly(6);
  endtask
  // send a byte msb first, return the acknowledge
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // take a byte msb first, then ack or not-ack on the last one
  task automatic byte_r(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule

// file: tb_psp_port.sv
// self-checking bench for the sensor serial target port
`timescale 1ns/1ps
module tb_psp_port
  import psp_pkg::*;
;
  logic clk, rst_n, scl, m_low, sda_o, oe, sel, st_t, st_p, scl_q, oe_q;
  logic t_vld = 1'b0;
  logic p_vld = 1'b0;
  logic [15:0] t_val, t_exp;
  logic [23:0] p_val, p_exp, v;
  wire sda_w;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n_t = 0;
  int n_p = 0;
  int t_at_p = 0;
  // open-drain data wire with pull-up
  assign sda_w = ~(m_low | (oe & ~sda_o));
  psp_port u_psp_port (.SYS_CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE_O(oe), .ADDR_SEL_I(sel), .TEMP_VALID_I(t_vld),
    .TEMP_DATA_I(t_val), .PRESS_VALID_I(p_vld), .PRESS_DATA_I(p_val),
    .START_TEMP_O(st_t), .START_PRESS_O(st_p));
  psp_master u_psp_master (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));
  // free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // conversion core: result arrives the cycle after each launch
  always @(negedge clk)
  begin
    t_vld <= st_t;
    p_vld <= st_p;
    if (st_t === 1'b1)
      n_t <= n_t + 1;
    if (st_p === 1'b1)
    begin
      n_p <= n_p + 1;
      t_at_p <= n_t;
    end
  end
  // watch device drive while clock high, and cut a hang short
  always @(posedge clk)
  begin
    #1;
    if (rst_n && scl && scl_q)
      chk("drive stable", oe_q, oe);
    scl_q = scl;
    oe_q = oe;
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  // compare and count
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // write one register: index byte then data byte
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    logic a;
    u_psp_master.start();
    u_psp_master.byte_w({OWN_ADDR_HI, sel, 1'b0}, a);
    chk("addr ack", 1, a);
    u_psp_master.byte_w(idx, a);
    chk("index ack", 1, a);
    u_psp_master.byte_w(d, a);
    chk("data ack", 1, a);
    u_psp_master.stop();
  endtask
  // set index, repeated start, read n bytes high first
  task automatic rd_reg(input logic [7:0] idx, input int n, output logic [23:0] r);
    logic a;
    logic [7:0] b;
    r = 24'h000000;
    u_psp_master.start();
    u_psp_master.byte_w({OWN_ADDR_HI, sel, 1'b0}, a);
    u_psp_master.byte_w(idx, a);
    u_psp_master.start();
    u_psp_master.byte_w({OWN_ADDR_HI, sel, 1'b1}, a);
    chk("read ack", 1, a);
    for (int i = 0; i < n; i++)
    begin
      u_psp_master.byte_r(i == n - 1, b);
      r = {r[15:0], b};
    end
    u_psp_master.stop();
  endtask
  // all result registers read zero after reset
  task automatic t_reset();
    rd_reg(IDX_P_HI, 3, v);
    chk("press reset", 24'h000000, v);
    rd_reg(IDX_T_HI, 2, v);
    chk("temp reset", 24'h000000, v);
    rd_reg(IDX_CMD, 1, v);
    chk("cmd reset", 24'h000000, v);
  endtask
  // launch by command code, count launches, read both results
  task automatic t_conv(input logic [3:0] code, input int nt, input int np);
    t_val = {code, 12'h5A1};
    p_val = {code, 20'hC3E7B};
    n_t = 0;
    n_p = 0;
    wr_reg(IDX_CMD, {4'h5, code});
    u_psp_master.dly(4);
    chk("temp launches", nt, n_t);
    chk("press launches", np, n_p);
    if (np == 1)
      chk("temp before press", nt, t_at_p);
    if (nt == 1)
      t_exp = t_val;
    if (np == 1)
      p_exp = p_val;
    rd_reg(IDX_P_HI, 3, v);
    chk("pressure", p_exp, v);
    rd_reg(IDX_T_HI, 2, v);
    chk("temperature", {8'h00, t_exp}, v);
    rd_reg(IDX_CMD, 1, v);
    chk("cmd readback", {16'h0000, 4'h5, code}, v);
  endtask
  // other address is ignored, pin-selected address answers
  task automatic t_addr();
    logic a;
    sel = 1'b1;
    u_psp_master.start();
    u_psp_master.byte_w({OWN_ADDR_HI, 1'b0, 1'b0}, a);
    chk("foreign addr", 0, a);
    u_psp_master.byte_w(IDX_CMD, a);
    chk("ignored byte", 0, a);
    u_psp_master.stop();
    rd_reg(IDX_T_HI, 2, v);
    chk("pin addr read", {8'h00, t_exp}, v);
  endtask
  // pressure register refuses writes; unmapped index reads zero
  task automatic t_ro();
    wr_reg(IDX_P_HI, 8'hFF);
    rd_reg(IDX_P_HI, 3, v);
    chk("press read-only", p_exp, v);
    rd_reg(8'h20, 1, v);
    chk("unmapped", 24'h000000, v);
  endtask
  // two data bytes in one write land at successive indices
  task automatic t_burst();
    logic a;
    u_psp_master.start();
    u_psp_master.byte_w({OWN_ADDR_HI, sel, 1'b0}, a);
    u_psp_master.byte_w(IDX_CMD - 8'h01, a);
    u_psp_master.byte_w(8'hFF, a);
    chk("burst first ack", 1, a);
    u_psp_master.byte_w(8'h6B, a);
    chk("burst second ack", 1, a);
    u_psp_master.stop();
    rd_reg(IDX_CMD, 1, v);
    chk("burst cmd", 24'h00006B, v);
  endtask
  // reset in mid-run clears every register again
  task automatic t_rst();
    rst_n = 1'b0;
    u_psp_master.dly(4);
    rst_n = 1'b1;
    u_psp_master.dly(2);
    t_reset();
  endtask
  // closing report and verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    sel = 1'b0;
    t_val = 16'h0000;
    p_val = 24'h000000;
    t_exp = 16'h0000;
    p_exp = 24'h000000;
    scl_q = 1'b1;
    oe_q = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_conv(4'h8, 1, 0);
    t_conv(4'h9, 0, 1);
    t_conv(4'hA, 1, 1);
    t_conv(4'h3, 0, 0);
    t_addr();
    t_ro();
    t_burst();
    t_rst();
    report_and_stop();
  end
endmodule
